// ==== timer0_pkg.sv ====
package timer0_pkg;

	// cpu address space
	localparam logic [7:0] IO_SHIFT    = 8'h20;
	localparam logic [7:0] IO_LIMIT    = 8'h40;
	localparam logic [7:0] OFF_FLAGS   = 8'h35;
	localparam logic [7:0] OFF_GTCTRL  = 8'h43;
	localparam logic [7:0] OFF_COUNT   = 8'h46;
	localparam logic [7:0] OFF_CMPA    = 8'h47;
	localparam logic [7:0] OFF_CMPB    = 8'h48;
	localparam logic [7:0] OFF_MASK    = 8'h6E;

	// field positions
	localparam int BIT_OVF        = 0;
	localparam int BIT_CMPA       = 1;
	localparam int BIT_CMPB       = 2;
	localparam int BIT_SYNC_CLR   = 0;
	localparam int BIT_ASYNC_CLR  = 1;
	localparam int BIT_SYNC_HOLD  = 7;

	// reset values
	localparam logic [7:0] RST_COUNT  = 8'h00;
	localparam logic [7:0] RST_CMP    = 8'h00;
	localparam logic [2:0] RST_FLAGS  = 3'h0;
	localparam logic [2:0] RST_MASK   = 3'h0;
	localparam logic [9:0] RST_PRE    = 10'h000;

	// counter landmarks
	localparam logic [7:0] CNT_MAX    = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;

	// waveform_mode_sel codes
	localparam logic [2:0] MODE_NORMAL    = 3'h0;
	localparam logic [2:0] MODE_PC_FULL   = 3'h1;
	localparam logic [2:0] MODE_CTC       = 3'h2;
	localparam logic [2:0] MODE_FAST_FULL = 3'h3;
	localparam logic [2:0] MODE_PC_CMPA   = 3'h5;
	localparam logic [2:0] MODE_FAST_CMPA = 3'h7;

	// clock select codes and prescaler tap masks
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam logic [9:0] TAP_8       = 10'h007;
	localparam logic [9:0] TAP_64      = 10'h03F;
	localparam logic [9:0] TAP_256     = 10'h0FF;
	localparam logic [9:0] TAP_1024    = 10'h3FF;

	typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_e;

endpackage

// ==== timer0_prescaler.sv ====
`timescale 1ns/1ps
module timer0_prescaler (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// control
	input  wire logic       preClear,
	input  wire logic [2:0] clkSel,
	input  wire logic       extPin,
	// timer clock enable
	output logic            tick
);
	typedef struct packed {
		logic [9:0] pre;
		logic [2:0] pinSync;
		logic       pinLevel;
		logic       tick;
	} pre_s;

	pre_s s_r;
	pre_s s_nxt;

	function automatic logic tapHit(input logic [9:0] pre,
		input logic [9:0] mask);
		tapHit = ((pre & mask) == mask);
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.pinSync = {s_r.pinSync[1:0], extPin};
		// level changes only once stages two and three agree
		if (s_r.pinSync[1] == s_r.pinSync[2]) begin
			s_nxt.pinLevel = s_r.pinSync[2];
		end
		s_nxt.pre = preClear ? timer0_pkg::RST_PRE : 10'(s_r.pre + 10'h001);
		case (clkSel)
			timer0_pkg::CS_STOP:     s_nxt.tick = 1'b0;
			timer0_pkg::CS_DIV1:     s_nxt.tick = 1'b1;
			timer0_pkg::CS_DIV8:     s_nxt.tick = tapHit(s_r.pre, timer0_pkg::TAP_8);
			timer0_pkg::CS_DIV64:    s_nxt.tick = tapHit(s_r.pre, timer0_pkg::TAP_64);
			timer0_pkg::CS_DIV256:   s_nxt.tick = tapHit(s_r.pre, timer0_pkg::TAP_256);
			timer0_pkg::CS_DIV1024:  s_nxt.tick = tapHit(s_r.pre, timer0_pkg::TAP_1024);
			timer0_pkg::CS_EXT_FALL: s_nxt.tick = s_r.pinLevel & ~s_nxt.pinLevel;
			timer0_pkg::CS_EXT_RISE: s_nxt.tick = ~s_r.pinLevel & s_nxt.pinLevel;
			default:                 s_nxt.tick = 1'b0;
		endcase
		// a held prescaler clear halts internal sources, direct clock too
		if (preClear && clkSel != timer0_pkg::CS_EXT_FALL
			&& clkSel != timer0_pkg::CS_EXT_RISE) begin
			s_nxt.tick = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;

endmodule

// ==== timer0_regs.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// (R1) compare-A request needs its enable, global enable and its flag
// (R2) overflow request needs its enable, global enable and its flag
// (R3) with hold mode on, written prescaler-clear bits stay and keep resets
// (R4) writing hold mode zero clears both prescaler-clear bits
// (R5) sync prescaler clear resets the prescaler shared by timers 0, 1, 3
// (R6) sync prescaler clear drops after one cycle unless hold mode is on
// (R7) counter register reads and loads the 8-bit counter directly
// (R8) a counter write suppresses compare match on the next timer tick
// (R9) compare-A equality raises its flag or drives wave output A
// (R10) compare-B equality raises its flag or drives wave output B
// (R11) compare-B flag sets on match, clears by vector or write-one
// (R12) compare-A flag sets on match, clears by vector or write-one
// (R13) overflow flag sets on overflow, clears by vector or write-one
// (R14) compare-B request needs its enable, global enable and its flag
// (R15) overflow point follows the waveform mode, not one fixed count
// (R16) short io addresses decode at data offset minus 0x20, 0x00..0x3F
// (R17) software reaches extended registers only by data-space access
// (R18) forced compare drives wave output only, in non-pwm modes, no flag, no clear
// (R19) hardware set beats write-one clear in the same cycle
module timer0_regs (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// cpu register port
	input  wire logic [7:0] ioAddr,
	input  wire logic       ioSpace,
	input  wire logic       wrEn,
	input  wire logic       rdEn,
	input  wire logic [7:0] wrData,
	output logic      [7:0] rdData,
	// cpu core status
	input  wire logic       globalIrqEn,
	input  wire logic       ackCmpA,
	input  wire logic       ackCmpB,
	input  wire logic       ackOvf,
	// timer setup
	input  wire logic [2:0] waveModeSel,
	input  wire logic [2:0] clkSel,
	input  wire logic       forceCmpA,
	input  wire logic       forceCmpB,
	input  wire logic       extPin,
	// interrupt requests
	output logic            irqCmpA,
	output logic            irqCmpB,
	output logic            irqOvf,
	// compare match to waveform unit
	output logic            matchA,
	output logic            matchB,
	// shared prescaler resets
	output logic            syncPrescalerReset,
	output logic            asyncPrescalerReset
);
	typedef struct packed {
		logic [7:0]        counterValue;
		logic [7:0]        compareAValue;
		logic [7:0]        compareBValue;
		logic [2:0]        flags;
		logic [2:0]        mask;
		logic              syncHoldMode;
		logic              syncPrescalerClear;
		logic              asyncPrescalerClear;
		logic              blockCmp;
		timer0_pkg::dir_e  dir;
		logic [7:0]        rdData;
		logic [2:0]        irq;
		logic              matchA;
		logic              matchB;
	} regs_s;

	regs_s s_r;
	regs_s s_nxt;
	logic  tick;

	// io space is a window onto data space shifted by 0x20
	function automatic logic regHit(input logic [7:0] addr,
		input logic io, input logic [7:0] off);
		if (io) begin
			regHit = (addr < timer0_pkg::IO_LIMIT)
				&& (8'(addr + timer0_pkg::IO_SHIFT) == off);
		end else begin
			regHit = (addr == off);
		end
	endfunction

	function automatic logic nextFlag(input logic flag, input logic set,
		input logic clr);
		nextFlag = set | (flag & ~clr);
	endfunction

	timer0_prescaler u_prescaler (
		.clk      (clk),
		.rst      (rst),
		.preClear (s_r.syncPrescalerClear),
		.clkSel   (clkSel),
		.extPin   (extPin),
		.tick     (tick)
	);

	// decoded strobes
	logic       wrFlags;
	logic       wrGtCtrl;
	logic       wrCount;
	logic       wrCmpA;
	logic       wrCmpB;
	logic       wrMask;
	logic       isPwm;
	logic [7:0] top;
	logic       hitA;
	logic       hitB;
	logic       ovfHit;
	logic [2:0] setEv;
	logic [2:0] clrEv;

	always_comb begin
		// (R16) io address decode
		wrFlags  = wrEn && regHit(ioAddr, ioSpace, timer0_pkg::OFF_FLAGS);
		wrGtCtrl = wrEn && regHit(ioAddr, ioSpace, timer0_pkg::OFF_GTCTRL);
		wrCount  = wrEn && regHit(ioAddr, ioSpace, timer0_pkg::OFF_COUNT);
		wrCmpA   = wrEn && regHit(ioAddr, ioSpace, timer0_pkg::OFF_CMPA);
		wrCmpB   = wrEn && regHit(ioAddr, ioSpace, timer0_pkg::OFF_CMPB);
		// (R17) mask sits above the io window, data space only
		wrMask   = wrEn && regHit(ioAddr, ioSpace, timer0_pkg::OFF_MASK);

		isPwm = waveModeSel[0];
		case (waveModeSel)
			timer0_pkg::MODE_CTC,
			timer0_pkg::MODE_PC_CMPA,
			timer0_pkg::MODE_FAST_CMPA: top = s_r.compareAValue;
			default:                    top = timer0_pkg::CNT_MAX;
		endcase

		// (R9) compare A equality
		hitA = tick && !s_r.blockCmp
			&& (s_r.counterValue == s_r.compareAValue);
		// (R10) compare B equality
		hitB = tick && !s_r.blockCmp
			&& (s_r.counterValue == s_r.compareBValue);

		// (R15) overflow point per mode
		case (waveModeSel)
			timer0_pkg::MODE_PC_FULL,
			timer0_pkg::MODE_PC_CMPA: ovfHit = tick
				&& s_r.dir == timer0_pkg::DIR_DOWN
				&& s_r.counterValue == timer0_pkg::CNT_BOTTOM;
			timer0_pkg::MODE_FAST_CMPA: ovfHit = tick
				&& s_r.counterValue == top;
			default: ovfHit = tick
				&& s_r.counterValue == timer0_pkg::CNT_MAX;
		endcase
	end

	always_comb begin
		s_nxt = s_r;

		// counting sequence; phase correct reaches bottom before turning up
		if (tick) begin
			s_nxt.blockCmp = 1'b0;
			case (waveModeSel)
				timer0_pkg::MODE_PC_FULL,
				timer0_pkg::MODE_PC_CMPA: begin
					case (s_r.dir)
						timer0_pkg::DIR_UP: begin
							if (s_r.counterValue >= top) begin
								s_nxt.dir = timer0_pkg::DIR_DOWN;
								s_nxt.counterValue = 8'(s_r.counterValue - 8'h01);
							end else begin
								s_nxt.counterValue = 8'(s_r.counterValue + 8'h01);
							end
						end
						timer0_pkg::DIR_DOWN: begin
							if (s_r.counterValue == timer0_pkg::CNT_BOTTOM) begin
								s_nxt.dir = timer0_pkg::DIR_UP;
								s_nxt.counterValue = 8'(s_r.counterValue + 8'h01);
							end else begin
								s_nxt.counterValue = 8'(s_r.counterValue - 8'h01);
							end
						end
						default: s_nxt.dir = timer0_pkg::DIR_UP;
					endcase
				end
				default: begin
					s_nxt.dir = timer0_pkg::DIR_UP;
					if (s_r.counterValue == top) begin
						s_nxt.counterValue = timer0_pkg::CNT_BOTTOM;
					end else begin
						s_nxt.counterValue = 8'(s_r.counterValue + 8'h01);
					end
				end
			endcase
		end

		// (R7) cpu load wins over counting
		if (wrCount) begin
			s_nxt.counterValue = wrData;
			// (R8) blank next compare
			s_nxt.blockCmp = 1'b1;
		end
		if (wrCmpA) begin
			s_nxt.compareAValue = wrData;
		end
		if (wrCmpB) begin
			s_nxt.compareBValue = wrData;
		end
		if (wrMask) begin
			s_nxt.mask = wrData[2:0];
		end

		// (R5) sync clear drives the shared prescaler reset
		if (wrGtCtrl) begin
			s_nxt.syncHoldMode = wrData[timer0_pkg::BIT_SYNC_HOLD];
			s_nxt.syncPrescalerClear = wrData[timer0_pkg::BIT_SYNC_CLR];
			s_nxt.asyncPrescalerClear = wrData[timer0_pkg::BIT_ASYNC_CLR];
		end else if (!s_r.syncHoldMode) begin
			// (R6) self clear unless held
			s_nxt.syncPrescalerClear = 1'b0;
			// (R4) hold off releases both clears
			s_nxt.asyncPrescalerClear = 1'b0;
		end
		// (R3) hold mode keeps written clear bits

		// (R12) compare A flag events
		setEv[timer0_pkg::BIT_CMPA] = hitA;
		clrEv[timer0_pkg::BIT_CMPA] = ackCmpA
			|| (wrFlags && wrData[timer0_pkg::BIT_CMPA]);
		// (R11) compare B flag events
		setEv[timer0_pkg::BIT_CMPB] = hitB;
		clrEv[timer0_pkg::BIT_CMPB] = ackCmpB
			|| (wrFlags && wrData[timer0_pkg::BIT_CMPB]);
		// (R13) overflow flag events
		setEv[timer0_pkg::BIT_OVF] = ovfHit;
		clrEv[timer0_pkg::BIT_OVF] = ackOvf
			|| (wrFlags && wrData[timer0_pkg::BIT_OVF]);
		// (R19) set has priority over clear
		for (int i = 0; i < 3; i++) begin
			s_nxt.flags[i] = nextFlag(s_r.flags[i], setEv[i], clrEv[i]);
		end

		// (R1) compare A request gating
		s_nxt.irq[timer0_pkg::BIT_CMPA] = globalIrqEn
			&& s_r.mask[timer0_pkg::BIT_CMPA] && s_r.flags[timer0_pkg::BIT_CMPA];
		// (R14) compare B request gating
		s_nxt.irq[timer0_pkg::BIT_CMPB] = globalIrqEn
			&& s_r.mask[timer0_pkg::BIT_CMPB] && s_r.flags[timer0_pkg::BIT_CMPB];
		// (R2) overflow request gating
		s_nxt.irq[timer0_pkg::BIT_OVF] = globalIrqEn
			&& s_r.mask[timer0_pkg::BIT_OVF] && s_r.flags[timer0_pkg::BIT_OVF];

		// (R18) forced match reaches wave output only
		s_nxt.matchA = hitA || (forceCmpA && !isPwm);
		s_nxt.matchB = hitB || (forceCmpB && !isPwm);

		// read data holds until the next read; unmapped reads zero
		if (rdEn) begin
			s_nxt.rdData = 8'h00;
			if (regHit(ioAddr, ioSpace, timer0_pkg::OFF_FLAGS)) begin
				s_nxt.rdData = {5'h00, s_r.flags};
			end
			if (regHit(ioAddr, ioSpace, timer0_pkg::OFF_GTCTRL)) begin
				s_nxt.rdData = {s_r.syncHoldMode, 5'h00,
					s_r.asyncPrescalerClear, s_r.syncPrescalerClear};
			end
			if (regHit(ioAddr, ioSpace, timer0_pkg::OFF_COUNT)) begin
				s_nxt.rdData = s_r.counterValue;
			end
			if (regHit(ioAddr, ioSpace, timer0_pkg::OFF_CMPA)) begin
				s_nxt.rdData = s_r.compareAValue;
			end
			if (regHit(ioAddr, ioSpace, timer0_pkg::OFF_CMPB)) begin
				s_nxt.rdData = s_r.compareBValue;
			end
			if (regHit(ioAddr, ioSpace, timer0_pkg::OFF_MASK)) begin
				s_nxt.rdData = {5'h00, s_r.mask};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r.counterValue        <= timer0_pkg::RST_COUNT;
			s_r.compareAValue       <= timer0_pkg::RST_CMP;
			s_r.compareBValue       <= timer0_pkg::RST_CMP;
			s_r.flags               <= timer0_pkg::RST_FLAGS;
			s_r.mask                <= timer0_pkg::RST_MASK;
			s_r.syncHoldMode        <= 1'b0;
			s_r.syncPrescalerClear  <= 1'b0;
			s_r.asyncPrescalerClear <= 1'b0;
			s_r.blockCmp            <= 1'b0;
			s_r.dir                 <= timer0_pkg::DIR_UP;
			s_r.rdData              <= 8'h00;
			s_r.irq                 <= 3'h0;
			s_r.matchA              <= 1'b0;
			s_r.matchB              <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdData              = s_r.rdData;
	assign irqCmpA             = s_r.irq[timer0_pkg::BIT_CMPA];
	assign irqCmpB             = s_r.irq[timer0_pkg::BIT_CMPB];
	assign irqOvf              = s_r.irq[timer0_pkg::BIT_OVF];
	assign matchA              = s_r.matchA;
	assign matchB              = s_r.matchB;
	assign syncPrescalerReset  = s_r.syncPrescalerClear;
	assign asyncPrescalerReset = s_r.asyncPrescalerClear;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_irq_cmpa_gate: assert property ( // (R1)
		irqCmpA == $past(globalIrqEn && s_r.mask[1] && s_r.flags[1]))
		else $error("compare A request not gated by enable and flag");
	a_irq_ovf_gate: assert property ( // (R2)
		irqOvf == $past(globalIrqEn && s_r.mask[0] && s_r.flags[0]))
		else $error("overflow request not gated by enable and flag");
	a_irq_cmpb_gate: assert property ( // (R14)
		irqCmpB == $past(globalIrqEn && s_r.mask[2] && s_r.flags[2]))
		else $error("compare B request not gated by enable and flag");
	a_hold_keeps_clear: assert property ( // (R3)
		s_r.syncHoldMode && !wrGtCtrl |=> $stable(syncPrescalerReset)
			&& $stable(asyncPrescalerReset))
		else $error("held prescaler clear changed without a write");
	a_hold_release: assert property ( // (R4)
		wrGtCtrl && !wrData[7] ##1 !wrGtCtrl
			|=> !syncPrescalerReset && !asyncPrescalerReset)
		else $error("prescaler clear not released after hold off");
	a_sync_reset_out: assert property ( // (R5)
		wrGtCtrl && wrData[0] |=> syncPrescalerReset)
		else $error("sync prescaler clear did not reach reset output");
	a_sync_self_clear: assert property ( // (R6)
		syncPrescalerReset && !s_r.syncHoldMode && !wrGtCtrl
			|=> !syncPrescalerReset)
		else $error("sync prescaler clear failed to self clear");
	a_count_load: assert property ( // (R7)
		wrCount |=> s_r.counterValue == $past(wrData))
		else $error("counter write did not load the counter");
	a_write_blanks: assert property ( // (R8)
		wrCount ##1 !forceCmpA |=> !matchA)
		else $error("compare match after counter write");
	a_cmpa_flag_set: assert property ( // (R12)
		hitA |=> s_r.flags[1] && matchA)
		else $error("compare A hit did not set flag and match");
	a_cmpb_flag_set: assert property ( // (R11)
		hitB |=> s_r.flags[2] && matchB)
		else $error("compare B hit did not set flag and match");
	a_ovf_clear: assert property ( // (R13)
		ackOvf && !ovfHit |=> !s_r.flags[0])
		else $error("overflow flag not cleared by vector");
	a_force_no_flag: assert property ( // (R18)
		forceCmpA && !isPwm && !hitA && !s_r.flags[1]
			|=> matchA && !s_r.flags[1])
		else $error("forced compare touched flag or missed output");
	a_set_beats_clr: assert property ( // (R19)
		hitB && wrFlags && wrData[2] |=> s_r.flags[2])
		else $error("flag set lost to a write-one clear");
	a_io_read_count: assert property ( // (R16)
		rdEn && ioSpace
			&& ioAddr == 8'(timer0_pkg::OFF_COUNT - timer0_pkg::IO_SHIFT)
			|=> rdData == $past(s_r.counterValue))
		else $error("io read of counter misdecoded");

	c_hold_release: cover property (
		s_r.syncHoldMode && syncPrescalerReset ##1 wrGtCtrl && !wrData[7]);
	c_match_a: cover property (hitA && irqCmpA == 1'b0 ##2 irqCmpA);
	c_overflow: cover property (ovfHit ##1 s_r.flags[0]);
	c_force_b: cover property (forceCmpB && !isPwm ##1 matchB);

endmodule

// ==== cpu_model.sv ====
`timescale 1ns/1ps
module cpu_model (
	// clock
	input  wire logic       clk,
	// register port
	output logic      [7:0] ioAddr,
	output logic            ioSpace,
	output logic            wrEn,
	output logic            rdEn,
	output logic      [7:0] wrData,
	input  wire logic [7:0] rdData,
	// interrupt side
	output logic            globalIrqEn,
	output logic            ackCmpA,
	output logic            ackCmpB,
	output logic            ackOvf,
	input  wire logic       irqCmpA,
	input  wire logic       irqCmpB,
	input  wire logic       irqOvf,
	// behaviour knobs
	input  wire logic       autoAck,
	input  wire logic [7:0] ackLag
);
	logic [7:0] lagCnt;

	initial begin
		ioAddr = 8'h00;
		ioSpace = 1'b0;
		wrEn = 1'b0;
		rdEn = 1'b0;
		wrData = 8'h00;
		globalIrqEn = 1'b0;
		ackCmpA = 1'b0;
		ackCmpB = 1'b0;
		ackOvf = 1'b0;
		lagCnt = 8'h00;
	end

	// callers keep extended places to ioSpace low
	task automatic access(input logic io, input logic [7:0] a,
		input logic wr, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		ioSpace = io;
		ioAddr = a;
		wrData = d;
		wrEn = wr;
		rdEn = ~wr;
		@(negedge clk);
		q = rdData;
		wrEn = 1'b0;
		rdEn = 1'b0;
		// released lines toggle so stale data is never taken as valid
		ioAddr = ~ioAddr;
		wrData = ~wrData;
	endtask

	task automatic setGie(input logic v);
		globalIrqEn = v;
	endtask

	// vector taken ackLag cycles after a request; lag must stay above 2
	always @(negedge clk) begin
		ackCmpA <= 1'b0;
		ackCmpB <= 1'b0;
		ackOvf <= 1'b0;
		if (autoAck && (irqCmpA || irqCmpB || irqOvf)) begin
			lagCnt <= lagCnt + 8'h01;
			if (lagCnt == ackLag) begin
				lagCnt <= 8'h00;
				if (irqCmpA) ackCmpA <= 1'b1;
				else if (irqCmpB) ackCmpB <= 1'b1;
				else ackOvf <= 1'b1;
			end
		end else begin
			lagCnt <= 8'h00;
		end
	end
endmodule

// ==== tb_timer0_regs_irq_prescaler_sync.sv ====
`timescale 1ns/1ps
`define CHK(w, e, g) begin checks++; if ((g) !== (e)) begin \
	miscompares++; $display("ERROR %s expected %h seen %h", w, e, g); end end
module tb_timer0_regs_irq_prescaler_sync;
	logic       clk;
	logic       rst;
	logic [7:0] ioAddr;
	logic       ioSpace;
	logic       wrEn;
	logic       rdEn;
	logic [7:0] wrData;
	logic [7:0] rdData;
	logic       globalIrqEn;
	logic       ackCmpA;
	logic       ackCmpB;
	logic       ackOvf;
	logic [2:0] waveModeSel;
	logic [2:0] clkSel;
	logic       forceCmpA;
	logic       forceCmpB;
	logic       extPin;
	logic       irqCmpA;
	logic       irqCmpB;
	logic       irqOvf;
	logic       matchA;
	logic       matchB;
	logic       syncPrescalerReset;
	logic       asyncPrescalerReset;
	logic       autoAck;
	logic [7:0] ackLag;
	int         checks;
	int         miscompares;
	int         cycles;

	timer0_regs i_timer0_regs (.clk(clk), .rst(rst), .ioAddr(ioAddr),
		.ioSpace(ioSpace), .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData),
		.rdData(rdData), .globalIrqEn(globalIrqEn), .ackCmpA(ackCmpA),
		.ackCmpB(ackCmpB), .ackOvf(ackOvf), .waveModeSel(waveModeSel),
		.clkSel(clkSel), .forceCmpA(forceCmpA), .forceCmpB(forceCmpB),
		.extPin(extPin), .irqCmpA(irqCmpA), .irqCmpB(irqCmpB),
		.irqOvf(irqOvf), .matchA(matchA), .matchB(matchB),
		.syncPrescalerReset(syncPrescalerReset),
		.asyncPrescalerReset(asyncPrescalerReset));

	cpu_model i_cpu_model (.clk(clk), .ioAddr(ioAddr), .ioSpace(ioSpace),
		.wrEn(wrEn), .rdEn(rdEn), .wrData(wrData), .rdData(rdData),
		.globalIrqEn(globalIrqEn), .ackCmpA(ackCmpA), .ackCmpB(ackCmpB),
		.ackOvf(ackOvf), .irqCmpA(irqCmpA), .irqCmpB(irqCmpB),
		.irqOvf(irqOvf), .autoAck(autoAck), .ackLag(ackLag));

	always #2 clk = ~clk;

	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// a hang costs one mismatch; the whole run needs about 650 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		i_cpu_model.access(io, a, 1'b1, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		i_cpu_model.access(1'b0, a, 1'b0, 8'h00, q);
	endtask

	task automatic rdChk(input logic io, input logic [7:0] a,
		input logic [7:0] e, input string w);
		logic [7:0] x;
		i_cpu_model.access(io, a, 1'b0, 8'h00, x);
		`CHK(w, e, x)
	endtask

	task automatic tRegs();
		logic [7:0] offs [5];
		offs = '{timer0_pkg::OFF_FLAGS, timer0_pkg::OFF_GTCTRL,
			timer0_pkg::OFF_COUNT, timer0_pkg::OFF_CMPA, timer0_pkg::OFF_CMPB};
		foreach (offs[i]) rdChk(1'b0, offs[i], 8'h00, "reset value");
		rdChk(1'b0, timer0_pkg::OFF_MASK, 8'h00, "mask reset");
		wr(1'b1, 8'h27, 8'hA5);
		rdChk(1'b0, timer0_pkg::OFF_CMPA, 8'hA5, "cmpA via io");
		wr(1'b1, 8'h28, 8'h3C);
		rdChk(1'b1, 8'h28, 8'h3C, "cmpB via io");
		// io window ends at 0x3F, so 0x4E must miss the mask
		wr(1'b1, 8'h4E, 8'h07);
		rdChk(1'b0, timer0_pkg::OFF_MASK, 8'h00, "mask via io");
		rdChk(1'b0, 8'h50, 8'h00, "unmapped read");
		wr(1'b0, timer0_pkg::OFF_COUNT, 8'h9C);
		rdChk(1'b1, 8'h26, 8'h9C, "counter");
	endtask

	task automatic tForce();
		logic [2:0] modes [2];
		logic [3:0] na;
		logic [3:0] nb;
		modes = '{timer0_pkg::MODE_NORMAL, timer0_pkg::MODE_FAST_FULL};
		foreach (modes[m]) begin
			na = 4'h0;
			nb = 4'h0;
			waveModeSel = modes[m];
			@(negedge clk);
			forceCmpA = 1'b1;
			forceCmpB = 1'b1;
			repeat (5) begin
				@(negedge clk);
				forceCmpA = 1'b0;
				forceCmpB = 1'b0;
				na += {3'h0, matchA};
				nb += {3'h0, matchB};
			end
			`CHK("forced matchA", (m == 0) ? 4'h1 : 4'h0, na)
			`CHK("forced matchB", (m == 0) ? 4'h1 : 4'h0, nb)
		end
		waveModeSel = timer0_pkg::MODE_NORMAL;
		rdChk(1'b0, timer0_pkg::OFF_FLAGS, 8'h00, "flags after force");
	endtask

	task automatic tMatch();
		int n;
		logic [3:0] na;
		wr(1'b0, timer0_pkg::OFF_CMPA, 8'h30);
		wr(1'b0, timer0_pkg::OFF_CMPB, 8'h34);
		wr(1'b0, timer0_pkg::OFF_COUNT, 8'h2A);
		i_cpu_model.setGie(1'b1);
		clkSel = timer0_pkg::CS_DIV1;
		na = 4'h0;
		n = 0;
		while (matchB !== 1'b1 && n < 60) begin
			@(negedge clk);
			na += {3'h0, matchA};
			n++;
		end
		clkSel = timer0_pkg::CS_STOP;
		`CHK("matchA pulses", 4'h1, na)
		`CHK("matchB seen", 1'b1, matchB)
		idle(4);
		rdChk(1'b0, timer0_pkg::OFF_FLAGS, 8'h06, "flags on match");
		`CHK("irqA masked", 1'b0, irqCmpA)
		// mask lives in extended space: data-space access only
		wr(1'b0, timer0_pkg::OFF_MASK, 8'h06);
		idle(2);
		`CHK("irqA", 1'b1, irqCmpA)
		`CHK("irqB", 1'b1, irqCmpB)
		i_cpu_model.setGie(1'b0);
		idle(2);
		`CHK("irqA no gie", 1'b0, irqCmpA)
		`CHK("irqB no gie", 1'b0, irqCmpB)
		i_cpu_model.setGie(1'b1);
		wr(1'b0, timer0_pkg::OFF_FLAGS, 8'h02);
		idle(2);
		`CHK("irqA after w1c", 1'b0, irqCmpA)
		`CHK("irqB kept", 1'b1, irqCmpB)
		autoAck = 1'b1;
		idle(12);
		autoAck = 1'b0;
		rdChk(1'b0, timer0_pkg::OFF_FLAGS, 8'h00, "flags after ack");
	endtask

	task automatic tSuppress();
		logic [3:0] na;
		wr(1'b0, timer0_pkg::OFF_CMPA, 8'h55);
		wr(1'b0, timer0_pkg::OFF_COUNT, 8'h40);
		clkSel = timer0_pkg::CS_DIV1;
		wr(1'b0, timer0_pkg::OFF_COUNT, 8'h55);
		na = 4'h0;
		repeat (8) begin
			@(negedge clk);
			na += {3'h0, matchA};
		end
		clkSel = timer0_pkg::CS_STOP;
		`CHK("match after counter write", 4'h0, na)
		rdChk(1'b0, timer0_pkg::OFF_FLAGS, 8'h00, "no flag after write");
		// count lands one below compare B, so the hit meets the flag clear
		clkSel = timer0_pkg::CS_DIV1;
		wr(1'b0, timer0_pkg::OFF_COUNT, 8'h33);
		wr(1'b0, timer0_pkg::OFF_FLAGS, 8'h04);
		clkSel = timer0_pkg::CS_STOP;
		rdChk(1'b0, timer0_pkg::OFF_FLAGS, 8'h04, "set beats clear");
		wr(1'b0, timer0_pkg::OFF_FLAGS, 8'h04);
	endtask

	task automatic tOverflow();
		int n;
		wr(1'b0, timer0_pkg::OFF_MASK, 8'h01);
		wr(1'b0, timer0_pkg::OFF_COUNT, 8'hF8);
		ackLag = 8'd20;
		autoAck = 1'b1;
		clkSel = timer0_pkg::CS_DIV1;
		n = 0;
		while (irqOvf !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		`CHK("overflow irq", 1'b1, irqOvf)
		n = 0;
		while (irqOvf !== 1'b0 && n < 40) begin
			@(negedge clk);
			n++;
		end
		clkSel = timer0_pkg::CS_STOP;
		autoAck = 1'b0;
		`CHK("overflow irq cleared", 1'b0, irqOvf)
		rdChk(1'b0, timer0_pkg::OFF_FLAGS, 8'h00, "flags after ack");
		// compare-cleared mode wraps at 0x20 and never reaches 0xFF
		wr(1'b0, timer0_pkg::OFF_CMPA, 8'h20);
		wr(1'b0, timer0_pkg::OFF_COUNT, 8'h10);
		waveModeSel = timer0_pkg::MODE_CTC;
		clkSel = timer0_pkg::CS_DIV1;
		idle(300);
		clkSel = timer0_pkg::CS_STOP;
		idle(4);
		rdChk(1'b0, timer0_pkg::OFF_FLAGS, 8'h02, "ctc flags");
		// phase correct with compare-A top: overflow at bottom, not at 0xFF
		wr(1'b0, timer0_pkg::OFF_FLAGS, 8'h07);
		waveModeSel = timer0_pkg::MODE_PC_CMPA;
		wr(1'b0, timer0_pkg::OFF_COUNT, 8'h10);
		clkSel = timer0_pkg::CS_DIV1;
		idle(60);
		clkSel = timer0_pkg::CS_STOP;
		idle(4);
		rdChk(1'b0, timer0_pkg::OFF_FLAGS, 8'h03, "pc flags");
		waveModeSel = timer0_pkg::MODE_NORMAL;
	endtask

	task automatic tPrescaler();
		logic [3:0] np;
		logic [7:0] c1;
		logic [7:0] c2;
		// direct clock: only a held clear, not an idle tap, stops the count
		clkSel = timer0_pkg::CS_DIV1;
		wr(1'b0, timer0_pkg::OFF_GTCTRL, 8'h01);
		// the one-cycle pulse stands at the edge that ends the write
		np = {3'h0, syncPrescalerReset};
		repeat (4) begin
			@(negedge clk);
			np += {3'h0, syncPrescalerReset};
		end
		`CHK("sync clear pulse", 4'h1, np)
		rdChk(1'b1, 8'h23, 8'h00, "clear bit self-cleared");
		wr(1'b0, timer0_pkg::OFF_GTCTRL, 8'h83);
		rdChk(1'b0, timer0_pkg::OFF_GTCTRL, 8'h83, "hold keeps clears");
		`CHK("sync reset held", 1'b1, syncPrescalerReset)
		`CHK("async reset held", 1'b1, asyncPrescalerReset)
		rd(timer0_pkg::OFF_COUNT, c1);
		idle(40);
		rd(timer0_pkg::OFF_COUNT, c2);
		`CHK("counter halted", c1, c2)
		wr(1'b0, timer0_pkg::OFF_GTCTRL, 8'h00);
		idle(2);
		`CHK("sync reset freed", 1'b0, syncPrescalerReset)
		`CHK("async reset freed", 1'b0, asyncPrescalerReset)
		rdChk(1'b0, timer0_pkg::OFF_GTCTRL, 8'h00, "clears dropped");
		idle(40);
		rd(timer0_pkg::OFF_COUNT, c2);
		clkSel = timer0_pkg::CS_STOP;
		`CHK("counter resumes", 1'b1, c1 !== c2)
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		waveModeSel = timer0_pkg::MODE_NORMAL;
		clkSel = timer0_pkg::CS_STOP;
		forceCmpA = 1'b0;
		forceCmpB = 1'b0;
		extPin = 1'b0;
		autoAck = 1'b0;
		ackLag = 8'd3;
		checks = 0;
		miscompares = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		tRegs();
		tForce();
		tMatch();
		tSuppress();
		tOverflow();
		tPrescaler();
		summarize();
	end
endmodule
